// ### common/fcd_pkg.sv
// Constants, command codes and timing for the flash command decoder.
// Assumes a 40 MHz CPU clock and byte addresses from the internal memory bus.
package fcd_pkg;
	localparam int FCD_CMD_ADDR_BITS = 14;
	localparam int FCD_ADDR_WIDTH = 18;
	localparam int FCD_DATA_WIDTH = 16;

	localparam logic [13:0] FCD_UNLOCK1_ADDR = 14'h1554;
	localparam logic [13:0] FCD_UNLOCK2_ADDR = 14'h2AA8;
	localparam logic [13:0] FCD_PUNLOCK1_ADDR = 14'h2A54;
	localparam logic [13:0] FCD_PUNLOCK2_ADDR = 14'h15A8;
	localparam logic [1:0] FCD_ODD_WORD_LSB = 2'h2;

	localparam logic [7:0] FCD_KEY1_DATA = 8'hA8;
	localparam logic [7:0] FCD_KEY2_DATA = 8'h54;
	localparam logic [7:0] FCD_RESET_DATA = 8'hF0;
	localparam logic [7:0] FCD_PROGRAM_DATA = 8'hA0;
	localparam logic [7:0] FCD_ERASE_EN_DATA = 8'h80;
	localparam logic [7:0] FCD_BLOCK_ERASE_DATA = 8'h30;
	localparam logic [7:0] FCD_CHIP_ERASE_DATA = 8'h10;
	localparam logic [7:0] FCD_SUSPEND_DATA = 8'hB0;
	localparam logic [7:0] FCD_RESUME_DATA = 8'h30;
	localparam logic [7:0] FCD_SET_PROT_DATA = 8'hC0;
	localparam logic [7:0] FCD_READ_PROT_DATA = 8'h90;
	localparam logic [7:0] FCD_BLK_UNPROT_DATA = 8'hC1;
	localparam logic [15:0] FCD_CODE_UNPROT_WORD = 16'hFFFF;
	localparam logic [15:0] FCD_CODE_REPROT_WORD = 16'hFFFB;
	localparam logic [15:0] FCD_PROT_WORD_RESET = 16'hFFFF;

	localparam int FCD_CLK_MHZ = 40;
	localparam int FCD_ERASE_WINDOW_NS = 96000;
	localparam int FCD_ERASE_WINDOW_CYC = (FCD_ERASE_WINDOW_NS * FCD_CLK_MHZ) / 1000;

	localparam int FCD_P_RESET = 0;
	localparam int FCD_P_PROG = 1;
	localparam int FCD_P_BLOCK = 2;
	localparam int FCD_P_CHIP = 3;
	localparam int FCD_P_SUSP = 4;
	localparam int FCD_P_RESUME = 5;
	localparam int FCD_P_SETPROT = 6;
	localparam int FCD_P_PROTERR = 7;
	localparam int FCD_NPULSE = 8;

	function automatic logic fcd_match(input logic [13:0] addr, input logic [7:0] data,
		input logic [13:0] ca, input logic [7:0] cd);
		fcd_match = (addr == ca) && (data == cd);
	endfunction : fcd_match
endpackage : fcd_pkg

// ### hw/fcd_window_timer.sv
// Retriggerable timer for the block-erase address window.
// Assumes start and stop are one-cycle pulses on the same clock.
`timescale 1ns/100ps
module fcd_window_timer #(
	parameter int CYCLES = fcd_pkg::FCD_ERASE_WINDOW_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_stop,
	output logic o_open,
	output logic o_expired
);
	import fcd_pkg::*;
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	if (CYCLES < 2) begin : g_cycles_check
		$error("fcd_window_timer: CYCLES must be at least 2");
	end
	logic [CW-1:0] cnt_reg, cnt_next;
	logic open_reg, open_next, exp_reg, exp_next;
	always_comb begin
		cnt_next = cnt_reg;
		open_next = open_reg;
		exp_next = 1'b0;
		if (i_start) begin
			cnt_next = '0;
			open_next = 1'b1;
		end else if (i_stop) begin
			open_next = 1'b0;
		end else if (open_reg) begin
			if (cnt_reg == LAST) begin
				open_next = 1'b0;
				exp_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + CW'(1);
			end
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			open_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			open_reg <= open_next;
			exp_reg <= exp_next;
		end
	end
	assign o_open = open_reg;
	assign o_expired = exp_reg;
endmodule : fcd_window_timer

// ### hw/fcd_decoder.sv
// Command-sequence decoder of the on-chip flash.
// Assumes single-cycle write strobes from the CPU bus on the same clock and an erase/program
// controller that reports erase activity and suspension and carries out the pulsed commands.
`timescale 1ns/100ps
module fcd_decoder #(
	parameter int AW = fcd_pkg::FCD_ADDR_WIDTH,
	parameter int WINDOW_CYC = fcd_pkg::FCD_ERASE_WINDOW_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic [AW-1:0] i_addr,
	input wire logic [fcd_pkg::FCD_DATA_WIDTH-1:0] i_wdata,
	input wire logic i_from_flash,
	input wire logic i_in_flash,
	input wire logic i_erase_active,
	input wire logic i_erase_suspended,
	input wire logic i_addr_in_erase_blk,
	input wire logic [fcd_pkg::FCD_DATA_WIDTH-1:0] i_prot_reg,
	output logic o_read_reset,
	output logic o_program_start,
	output logic [AW-1:0] o_program_target_address,
	output logic [fcd_pkg::FCD_DATA_WIDTH-1:0] o_program_data_word,
	output logic o_block_erase_add,
	output logic [AW-1:0] o_erase_block_address,
	output logic o_chip_erase_start,
	output logic o_erase_suspend,
	output logic o_erase_resume,
	output logic o_set_protection,
	output logic [fcd_pkg::FCD_DATA_WIDTH-1:0] o_protection_write_word,
	output logic o_protection_error,
	output logic o_prot_read_mode,
	output logic [fcd_pkg::FCD_DATA_WIDTH-1:0] o_protection_register,
	output logic o_block_temp_unprot,
	output logic o_code_temp_unprot,
	output logic o_erase_window_open,
	output logic o_erase_window_expired
);
	import fcd_pkg::*;
	if (AW < FCD_CMD_ADDR_BITS) begin : g_aw_check
		$error("fcd_decoder: AW must cover the command address bits");
	end

	typedef enum logic [3:0] {
		FCD_READ, FCD_U1, FCD_U2, FCD_PROG_WAIT, FCD_ERASE_EN, FCD_EU1, FCD_EU2,
		FCD_ERASE_TO, FCD_P1, FCD_P2, FCD_SETPROT, FCD_BTU, FCD_RDPROT
	} fcd_state_type;

	fcd_state_type state_reg, state_next;
	logic [FCD_NPULSE-1:0] pulse_reg, pulse_next;
	logic [AW-1:0] paddr_reg, paddr_next, eaddr_reg, eaddr_next;
	logic [FCD_DATA_WIDTH-1:0] pdata_reg, pdata_next, pword_reg, pword_next, prd_reg, prd_next;
	logic rdmode_reg, rdmode_next, btu_reg, btu_next, ctu_reg, ctu_next, tmo_reg, tmo_next;
	logic win_open, win_exp;
	logic [13:0] ca;
	logic [7:0] lo;
	logic busy;

	// Upper address bits are dropped so one page pointer reaches every command address.
	assign ca = i_addr[13:0];
	assign lo = i_wdata[7:0];
	// A running erase accepts nothing but suspend, reset and the code unprotect/reprotect words.
	assign busy = i_erase_active & ~i_erase_suspended;

	fcd_window_timer #(
		.CYCLES(WINDOW_CYC)
	) u_window (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_start(pulse_reg[FCD_P_BLOCK]),
		.i_stop(pulse_reg[FCD_P_SUSP] | pulse_reg[FCD_P_RESET]),
		.o_open(win_open),
		.o_expired(win_exp)
	);

	always_comb begin
		state_next = state_reg;
		pulse_next = '0;
		paddr_next = paddr_reg;
		pdata_next = pdata_reg;
		eaddr_next = eaddr_reg;
		pword_next = pword_reg;
		btu_next = btu_reg;
		ctu_next = ctu_reg;
		if (i_wr) begin
			if (i_wdata == FCD_CODE_UNPROT_WORD && i_from_flash && i_in_flash) begin
				ctu_next = 1'b1;
				state_next = FCD_READ;
			end else if (i_wdata == FCD_CODE_REPROT_WORD && i_from_flash && i_in_flash) begin
				ctu_next = 1'b0;
				state_next = FCD_READ;
			end else if (lo == FCD_RESET_DATA) begin
				// One-cycle and three-cycle reset land here alike; unlock history only matters in FCD_BTU, where the reset also sets the block unprotect.
				pulse_next[FCD_P_RESET] = 1'b1;
				if (state_reg == FCD_BTU) begin
					btu_next = 1'b1;
				end
				state_next = FCD_READ;
			end else if (lo == FCD_SUSPEND_DATA && (busy || state_reg == FCD_ERASE_TO)) begin
				pulse_next[FCD_P_SUSP] = 1'b1;
				state_next = FCD_READ;
			end else if (!busy) begin
				state_next = FCD_READ;
				case (state_reg)
					FCD_READ, FCD_RDPROT: begin
						if (lo == FCD_RESUME_DATA && i_erase_suspended) begin
							pulse_next[FCD_P_RESUME] = 1'b1;
						end else if (fcd_match(ca, lo, FCD_UNLOCK1_ADDR, FCD_KEY1_DATA)) begin
							state_next = FCD_U1;
						end else if (fcd_match(ca, lo, FCD_PUNLOCK1_ADDR, FCD_KEY1_DATA)) begin
							state_next = FCD_P1;
						end
					end
					FCD_U1: begin
						if (fcd_match(ca, lo, FCD_UNLOCK2_ADDR, FCD_KEY2_DATA)) state_next = FCD_U2;
					end
					FCD_U2: begin
						if (fcd_match(ca, lo, FCD_UNLOCK1_ADDR, FCD_PROGRAM_DATA)) begin
							state_next = FCD_PROG_WAIT;
						end else if (fcd_match(ca, lo, FCD_UNLOCK1_ADDR, FCD_ERASE_EN_DATA) &&
							!i_erase_suspended) begin
							state_next = FCD_ERASE_EN;
						end
					end
					FCD_PROG_WAIT: begin
						// The full address is kept: the target is an array word, not a command.
						if (!(i_erase_suspended && i_addr_in_erase_blk)) begin
							pulse_next[FCD_P_PROG] = 1'b1;
							paddr_next = i_addr;
							pdata_next = i_wdata;
						end
					end
					FCD_ERASE_EN: begin
						if (fcd_match(ca, lo, FCD_UNLOCK1_ADDR, FCD_KEY1_DATA)) state_next = FCD_EU1;
					end
					FCD_EU1: begin
						if (fcd_match(ca, lo, FCD_UNLOCK2_ADDR, FCD_KEY2_DATA)) state_next = FCD_EU2;
					end
					FCD_EU2, FCD_ERASE_TO: begin
						if (lo == FCD_BLOCK_ERASE_DATA) begin
							pulse_next[FCD_P_BLOCK] = 1'b1;
							eaddr_next = i_addr;
							state_next = FCD_ERASE_TO;
						end else if (state_reg == FCD_EU2 &&
							fcd_match(ca, lo, FCD_UNLOCK1_ADDR, FCD_CHIP_ERASE_DATA)) begin
							pulse_next[FCD_P_CHIP] = 1'b1;
						end
					end
					FCD_P1: begin
						if (fcd_match(ca, lo, FCD_PUNLOCK2_ADDR, FCD_KEY2_DATA)) state_next = FCD_P2;
					end
					FCD_P2: begin
						if (fcd_match(ca, lo, FCD_PUNLOCK1_ADDR, FCD_SET_PROT_DATA)) begin
							state_next = FCD_SETPROT;
						end else if (fcd_match(ca, lo, FCD_PUNLOCK1_ADDR, FCD_READ_PROT_DATA)) begin
							state_next = FCD_RDPROT;
						end else if (fcd_match(ca, lo, FCD_PUNLOCK1_ADDR, FCD_BLK_UNPROT_DATA)) begin
							state_next = FCD_BTU;
						end
					end
					FCD_SETPROT: begin
						if (i_addr[1:0] == FCD_ODD_WORD_LSB) begin
							// A one may never be written over a zero already programmed.
							if ((~i_prot_reg & i_wdata) != '0) begin
								pulse_next[FCD_P_PROTERR] = 1'b1;
							end else begin
								pulse_next[FCD_P_SETPROT] = 1'b1;
								pword_next = i_wdata;
							end
						end
					end
					default: state_next = FCD_READ;
				endcase
			end
		end else if (state_reg == FCD_ERASE_TO && win_exp) begin
			state_next = FCD_READ;
		end
		rdmode_next = (state_next == FCD_RDPROT);
		prd_next = rdmode_next ? i_prot_reg : prd_reg;
		// An expiry in the same cycle as a new block write still reports the window closed.
		tmo_next = win_exp | (tmo_reg & ~pulse_next[FCD_P_BLOCK] & ~pulse_next[FCD_P_RESET]);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= FCD_READ;
			pulse_reg <= '0;
			paddr_reg <= '0;
			pdata_reg <= '0;
			eaddr_reg <= '0;
			pword_reg <= FCD_PROT_WORD_RESET;
			prd_reg <= FCD_PROT_WORD_RESET;
			rdmode_reg <= 1'b0;
			btu_reg <= 1'b0;
			ctu_reg <= 1'b0;
			tmo_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pulse_reg <= pulse_next;
			paddr_reg <= paddr_next;
			pdata_reg <= pdata_next;
			eaddr_reg <= eaddr_next;
			pword_reg <= pword_next;
			prd_reg <= prd_next;
			rdmode_reg <= rdmode_next;
			btu_reg <= btu_next;
			ctu_reg <= ctu_next;
			tmo_reg <= tmo_next;
		end
	end

	assign o_read_reset = pulse_reg[FCD_P_RESET];
	assign o_program_start = pulse_reg[FCD_P_PROG];
	assign o_program_target_address = paddr_reg;
	assign o_program_data_word = pdata_reg;
	assign o_block_erase_add = pulse_reg[FCD_P_BLOCK];
	assign o_erase_block_address = eaddr_reg;
	assign o_chip_erase_start = pulse_reg[FCD_P_CHIP];
	assign o_erase_suspend = pulse_reg[FCD_P_SUSP];
	assign o_erase_resume = pulse_reg[FCD_P_RESUME];
	assign o_set_protection = pulse_reg[FCD_P_SETPROT];
	assign o_protection_write_word = pword_reg;
	assign o_protection_error = pulse_reg[FCD_P_PROTERR];
	assign o_prot_read_mode = rdmode_reg;
	assign o_protection_register = prd_reg;
	assign o_block_temp_unprot = btu_reg;
	assign o_code_temp_unprot = ctu_reg;
	assign o_erase_window_open = win_open;
	assign o_erase_window_expired = tmo_reg;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	property p_reset;
		i_wr && lo == FCD_RESET_DATA && i_wdata != FCD_CODE_UNPROT_WORD |=> o_read_reset && !o_prot_read_mode;
	endproperty
	a_reset: assert property (p_reset) else $error("reset code did not reset");
	property p_suspend;
		i_wr && lo == FCD_SUSPEND_DATA && busy |=> o_erase_suspend;
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend not issued");
	property p_resume;
		i_wr && lo == FCD_RESUME_DATA && i_erase_suspended && state_reg == FCD_READ |=> o_erase_resume;
	endproperty
	a_resume: assert property (p_resume) else $error("resume not issued");
	property p_prog;
		state_reg == FCD_PROG_WAIT && i_wr && !busy && !i_erase_suspended && lo != FCD_RESET_DATA &&
			i_wdata[15:8] == 8'h12 |=> o_program_start && o_program_target_address == $past(i_addr);
	endproperty
	a_prog: assert property (p_prog) else $error("program not started with its address");
	property p_prog_blk;
		o_program_start |-> !($past(i_erase_suspended) && $past(i_addr_in_erase_blk));
	endproperty
	a_prog_blk: assert property (p_prog_blk) else $error("program into suspended block");
	property p_rdprot;
		o_prot_read_mode && !i_wr |=> o_prot_read_mode && o_protection_register == $past(i_prot_reg);
	endproperty
	a_rdprot: assert property (p_rdprot) else $error("protection readout lost");
	property p_ctu;
		i_wr && i_wdata == FCD_CODE_UNPROT_WORD && !i_from_flash && !o_code_temp_unprot |=> !o_code_temp_unprot;
	endproperty
	a_ctu: assert property (p_ctu) else $error("code unprotect honoured outside flash");
	property p_addr;
		state_reg == FCD_READ && i_wr && !busy && ca == FCD_UNLOCK1_ADDR && lo == FCD_KEY1_DATA
			|=> state_reg == FCD_U1;
	endproperty
	a_addr: assert property (p_addr) else $error("unlock missed on upper address bits");
	property p_prot_err;
		state_reg == FCD_SETPROT && i_wr && lo != FCD_RESET_DATA && i_addr[1:0] == FCD_ODD_WORD_LSB &&
			(~i_prot_reg & i_wdata) != '0 && i_wdata != FCD_CODE_UNPROT_WORD
			|=> o_protection_error && !o_set_protection;
	endproperty
	a_prot_err: assert property (p_prot_err) else $error("protection error not flagged");
	property p_chip;
		state_reg == FCD_EU2 && i_wr && !busy && ca == FCD_UNLOCK1_ADDR && lo == FCD_CHIP_ERASE_DATA
			|=> o_chip_erase_start ##1 !o_chip_erase_start;
	endproperty
	a_chip: assert property (p_chip) else $error("chip erase not one pulse");
	property p_btu;
		state_reg == FCD_BTU && i_wr && lo == FCD_RESET_DATA && i_wdata != FCD_CODE_UNPROT_WORD
			|=> o_block_temp_unprot;
	endproperty
	a_btu: assert property (p_btu) else $error("block unprotect not set");
	c_prog: cover property (o_program_start);
	c_block: cover property (o_block_erase_add ##[1:20] o_block_erase_add);
	c_rdprot: cover property (o_prot_read_mode ##1 o_prot_read_mode);
endmodule : fcd_decoder

// ### dv/fcd_cpu_model.sv
// CPU bus writer and erase controller stand-in for the flash command decoder.
// Assumes one-cycle decoder pulses on i_sys_clk; erase blocks are addresses with [17:15] all ones.
`timescale 1ns/100ps
module fcd_cpu_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_chip_erase_start,
	input wire logic i_window_expired,
	input wire logic i_erase_suspend,
	input wire logic i_erase_resume,
	input wire logic i_read_reset,
	output logic o_wr,
	output logic [17:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_from_flash,
	output logic o_in_flash,
	output logic o_erase_active,
	output logic o_erase_suspended,
	output logic o_addr_in_erase_blk,
	output logic [15:0] o_prot_reg
);
	logic active_reg;
	logic susp_reg;
	logic exp_reg;
	initial begin
		o_wr = 1'b0;
		o_addr = 18'h00000;
		o_wdata = 16'h0000;
		o_from_flash = 1'b0;
	end
	assign o_in_flash = o_from_flash;
	assign o_erase_active = active_reg;
	assign o_erase_suspended = susp_reg;
	assign o_addr_in_erase_blk = (o_addr[17:15] == 3'h7);
	// The erase runs until a reset write aborts it, so busy refusals stay testable.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			active_reg <= 1'b0;
			susp_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			exp_reg <= i_window_expired;
			if (i_read_reset) begin
				active_reg <= 1'b0;
				susp_reg <= 1'b0;
			end else if (i_chip_erase_start || (i_window_expired && !exp_reg)) begin
				active_reg <= 1'b1;
			end
			if (i_erase_suspend) begin
				susp_reg <= 1'b1;
			end else if (i_erase_resume) begin
				susp_reg <= 1'b0;
			end
		end
	end
	// Released bus shows inverted values so stale data never looks valid.
	task automatic write(input logic [17:0] a, input logic [15:0] d, input logic fl);
		@(negedge i_sys_clk);
		o_wr = 1'b1;
		o_addr = a;
		o_wdata = d;
		o_from_flash = fl;
		@(negedge i_sys_clk);
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		o_from_flash = 1'b0;
	endtask : write
endmodule : fcd_cpu_model

// ### dv/testbench.sv
// Self-checking bench for the flash command decoder with a queue of expected pulses.
// Assumes fcd_pkg and the CPU model; window shortened to 20 cycles.
`timescale 1ns/100ps
module testbench;
	import fcd_pkg::*;
	localparam int WIN = 20;
	logic sys_clk, rst_n, wr, from_flash, in_flash, busy, susp, in_blk;
	logic read_reset, prog_start, blk_add, chip_start, suspend, resume, set_prot, prot_err;
	logic prot_mode, block_temp_unprotect_cmd, code_temp_unprotect_cmd, win_open, win_exp;
	logic [17:0] addr, prog_addr, blk_addr, a;
	logic [15:0] wdata, prot_reg, prog_data, prot_word, prot_copy, d, ok;
	logic [37:0] notes[$];
	int fail_count, n_compared, cycles;
	fcd_decoder #(.AW(18), .WINDOW_CYC(WIN)) dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_wr(wr),
		.i_addr(addr), .i_wdata(wdata), .i_from_flash(from_flash), .i_in_flash(in_flash),
		.i_erase_active(busy), .i_erase_suspended(susp), .i_addr_in_erase_blk(in_blk), .i_prot_reg(prot_reg),
		.o_read_reset(read_reset), .o_program_start(prog_start), .o_program_target_address(prog_addr),
		.o_program_data_word(prog_data), .o_block_erase_add(blk_add), .o_erase_block_address(blk_addr),
		.o_chip_erase_start(chip_start), .o_erase_suspend(suspend), .o_erase_resume(resume),
		.o_set_protection(set_prot), .o_protection_write_word(prot_word), .o_protection_error(prot_err),
		.o_prot_read_mode(prot_mode), .o_protection_register(prot_copy), .o_block_temp_unprot(block_temp_unprotect_cmd),
		.o_code_temp_unprot(code_temp_unprotect_cmd), .o_erase_window_open(win_open), .o_erase_window_expired(win_exp));
	fcd_cpu_model cpu_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_chip_erase_start(chip_start),
		.i_window_expired(win_exp), .i_erase_suspend(suspend), .i_erase_resume(resume),
		.i_read_reset(read_reset), .o_wr(wr), .o_addr(addr), .o_wdata(wdata), .o_from_flash(from_flash),
		.o_in_flash(in_flash), .o_erase_active(busy), .o_erase_suspended(susp),
		.o_addr_in_erase_blk(in_blk), .o_prot_reg(prot_reg));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	function automatic logic [37:0] ev(input int k, input logic [17:0] ea, input logic [15:0] ed);
		ev = {k[3:0], ea, ed};
	endfunction : ev
	// Upper address bits are random so command matching must ignore them.
	function automatic logic [17:0] ca(input logic [13:0] lo);
		ca = {4'($urandom), lo};
	endfunction : ca
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic check(input logic [37:0] seen, input logic [37:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic got(input logic [37:0] seen);
		logic [37:0] exp;
		exp = '1;
		if (notes.size() > 0) exp = notes.pop_front();
		check(seen, exp);
	endtask : got
	task automatic cmd(input logic [17:0] ca_in, input logic [7:0] c);
		cpu_u.write(ca_in, {8'h12, c}, 1'b0);
	endtask : cmd
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : idle
	task automatic unlock(input logic prot);
		cmd(ca(prot ? FCD_PUNLOCK1_ADDR : FCD_UNLOCK1_ADDR), FCD_KEY1_DATA);
		cmd(ca(prot ? FCD_PUNLOCK2_ADDR : FCD_UNLOCK2_ADDR), FCD_KEY2_DATA);
	endtask : unlock
	task automatic prog(input logic [17:0] pa, input logic [15:0] pd);
		unlock(1'b0);
		cmd(ca(FCD_UNLOCK1_ADDR), FCD_PROGRAM_DATA);
		cpu_u.write(pa, pd, 1'b0);
	endtask : prog
	task automatic erase_pre();
		unlock(1'b0);
		cmd(ca(FCD_UNLOCK1_ADDR), FCD_ERASE_EN_DATA);
		unlock(1'b0);
	endtask : erase_pre
	always @(negedge sys_clk) begin
		if (rst_n) begin
			if (read_reset) got(ev(FCD_P_RESET, 18'h0, 16'h0));
			if (prog_start) got(ev(FCD_P_PROG, prog_addr, prog_data));
			if (blk_add) got(ev(FCD_P_BLOCK, blk_addr, 16'h0));
			if (chip_start) got(ev(FCD_P_CHIP, 18'h0, 16'h0));
			if (suspend) got(ev(FCD_P_SUSP, 18'h0, 16'h0));
			if (resume) got(ev(FCD_P_RESUME, 18'h0, 16'h0));
			if (prot_err) got(ev(FCD_P_PROTERR, 18'h0, 16'h0));
			else if (set_prot) got(ev(FCD_P_SETPROT, 18'h0, prot_word));
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		fail_count = 0;
		n_compared = 0;
		cycles = 0;
		rst_n = 1'b0;
		void'($urandom(98));
		cpu_u.o_prot_reg = 16'($urandom) & 16'hFFFB;
		idle(20);
		rst_n = 1'b1;
		check(38'(prot_word), 38'(FCD_PROT_WORD_RESET));
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		unlock(1'b0);
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		a = 18'($urandom);
		d = {8'h12, 1'b0, 7'($urandom)};
		notes.push_back(ev(FCD_P_PROG, a, d));
		prog(a, d);
		cmd(ca(FCD_UNLOCK1_ADDR), FCD_KEY1_DATA);
		cmd(ca(FCD_UNLOCK2_ADDR), 8'h55);
		cmd(ca(FCD_UNLOCK1_ADDR), FCD_PROGRAM_DATA);
		cpu_u.write(a, d, 1'b0);
		erase_pre();
		notes.push_back(ev(FCD_P_BLOCK, a, 16'h0));
		cmd(a, FCD_BLOCK_ERASE_DATA);
		idle(3);
		check(38'(win_open), 38'h1);
		a = 18'($urandom);
		notes.push_back(ev(FCD_P_BLOCK, a, 16'h0));
		cmd(a, FCD_BLOCK_ERASE_DATA);
		idle(WIN + 6);
		check(38'({win_open, win_exp}), 38'h1);
		notes.push_back(ev(FCD_P_SUSP, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_SUSPEND_DATA);
		idle(3);
		prog({3'h7, 15'($urandom)}, d);
		a = {1'b0, 17'($urandom)};
		notes.push_back(ev(FCD_P_PROG, a, d));
		prog(a, d);
		notes.push_back(ev(FCD_P_RESUME, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESUME_DATA);
		idle(3);
		prog(a, d);
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		erase_pre();
		notes.push_back(ev(FCD_P_CHIP, 18'h0, 16'h0));
		cmd(ca(FCD_UNLOCK1_ADDR), FCD_CHIP_ERASE_DATA);
		idle(3);
		prog(a, d);
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		unlock(1'b1);
		cmd(ca(FCD_PUNLOCK1_ADDR), FCD_READ_PROT_DATA);
		idle(3);
		check({21'h0, prot_mode, prot_copy}, {21'h1, prot_reg});
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		idle(3);
		check(38'(prot_mode), 38'h0);
		ok = prot_reg & 16'($urandom) & 16'hFF7F;
		unlock(1'b1);
		cmd(ca(FCD_PUNLOCK1_ADDR), FCD_SET_PROT_DATA);
		notes.push_back(ev(FCD_P_SETPROT, 18'h0, ok));
		cpu_u.write({16'($urandom), 2'h2}, ok, 1'b0);
		unlock(1'b1);
		cmd(ca(FCD_PUNLOCK1_ADDR), FCD_SET_PROT_DATA);
		notes.push_back(ev(FCD_P_PROTERR, 18'h0, 16'h0));
		cpu_u.write({16'($urandom), 2'h2}, 16'hFFFF, 1'b0);
		unlock(1'b1);
		cmd(ca(FCD_PUNLOCK1_ADDR), FCD_SET_PROT_DATA);
		cpu_u.write({16'($urandom), 2'h0}, ok, 1'b0);
		check(38'({block_temp_unprotect_cmd, code_temp_unprotect_cmd}), 38'h0);
		unlock(1'b1);
		cmd(ca(FCD_PUNLOCK1_ADDR), FCD_BLK_UNPROT_DATA);
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		idle(3);
		check(38'(block_temp_unprotect_cmd), 38'h1);
		cpu_u.write(18'($urandom), FCD_CODE_UNPROT_WORD, 1'b1);
		idle(3);
		check(38'(code_temp_unprotect_cmd), 38'h1);
		cpu_u.write(18'($urandom), FCD_CODE_REPROT_WORD, 1'b0);
		idle(3);
		check(38'(code_temp_unprotect_cmd), 38'h1);
		cpu_u.write(18'($urandom), FCD_CODE_REPROT_WORD, 1'b1);
		idle(3);
		check(38'(code_temp_unprotect_cmd), 38'h0);
		erase_pre();
		notes.push_back(ev(FCD_P_BLOCK, a, 16'h0));
		cmd(a, FCD_BLOCK_ERASE_DATA);
		idle(3);
		notes.push_back(ev(FCD_P_SUSP, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_SUSPEND_DATA);
		idle(WIN + 3);
		check(38'({win_open, win_exp}), 38'h0);
		// Erase enable is refused while suspended, so no chip erase pulse may follow.
		erase_pre();
		cmd(ca(FCD_UNLOCK1_ADDR), FCD_CHIP_ERASE_DATA);
		notes.push_back(ev(FCD_P_RESET, 18'h0, 16'h0));
		cmd(ca(14'($urandom)), FCD_RESET_DATA);
		idle(2);
		rst_n = 1'b0;
		idle(2);
		rst_n = 1'b1;
		check(38'({block_temp_unprotect_cmd, prot_word}), 38'(FCD_PROT_WORD_RESET));
		idle(5);
		check(38'(notes.size()), 38'h0);
		stop_test();
	end
endmodule : testbench
